// [shared/ssd_pkg.sv]
// Summary of operation
// RULE_01: mode field value one enables the sweep; any value except one or two is off.
// RULE_02: while sweep is selected, a sawtooth is added to the set value.
// RULE_03: mode field value two enables diameter correction of the ramp output.
// RULE_04: bits 7:4 select source: 0/1 second analog, 2 reserved, 3 digital, 4 auxiliary.
// RULE_05: digital source value is held within zero to one hundred percent.
// RULE_06: sweep amplitude is rate limited; ramp time is for a full 100 percent change.
// RULE_07: sweep period is a rise time plus a fall time, each 0 to 20.00 s.
// RULE_08: offset ramps linearly zero to amplitude over rise, back over fall, repeating.
// RULE_09: diameter signal is clamped to zero to one hundred percent.
// RULE_10: zero percent diameter leaves the ramp output speed unchanged.
// RULE_11: diameter ratio is accepted from 0.010 to 0.990 in steps of 0.001.
// RULE_12: output equals ramp speed over one plus diameter times (1/ratio minus one).
// RULE_13: diameter signal is rate limited by the shared ramp time, 0 to 20.00 s.
package ssd_pkg;
  // register indices on the plain register port
  localparam logic [2:0] REG_MODE = 3'h0;
  localparam logic [2:0] REG_DIGITAL = 3'h1;
  localparam logic [2:0] REG_RAMP_TIME = 3'h2;
  localparam logic [2:0] REG_RISE_TIME = 3'h3;
  localparam logic [2:0] REG_FALL_TIME = 3'h4;
  localparam logic [2:0] REG_RATIO = 3'h5;
  localparam logic [2:0] REG_STAT_SOURCE = 3'h6;
  localparam logic [2:0] REG_STAT_OFFSET = 3'h7;
  // mode register fields
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 3;
  localparam int SRC_LSB = 4;
  localparam int SRC_MSB = 7;
  localparam logic [3:0] MODE_SWEEP = 4'h1;
  localparam logic [3:0] MODE_DIAM = 4'h2;
  localparam logic [3:0] SRC_AN2_A = 4'h0;
  localparam logic [3:0] SRC_AN2_B = 4'h1;
  localparam logic [3:0] SRC_DIGITAL = 4'h3;
  localparam logic [3:0] SRC_AUX = 4'h4;
  // scaling: 16'h4000 is 100 percent, times in 0.01 s, ratio in 0.001
  localparam logic signed [15:0] FULL_SCALE = 16'sh4000;
  localparam logic [15:0] TIME_MAX = 16'h07d0;
  localparam logic [15:0] RATIO_MIN = 16'h000a;
  localparam logic [15:0] RATIO_MAX = 16'h03de;
  localparam logic [10:0] RATIO_ONE = 11'h3e8;
  // reset values
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_DIGITAL = 16'h0000;
  localparam logic [15:0] RST_RAMP_TIME = 16'h0000;
  localparam logic [15:0] RST_RISE_TIME = 16'h0064;
  localparam logic [15:0] RST_FALL_TIME = 16'h0064;
  localparam logic [15:0] RST_RATIO = 16'h01f4;
  // timing: one time unit is 0.01 s
  localparam longint TIME_UNIT_NS = 10000000;
  localparam longint CLK_PERIOD_NS = 20;
  localparam int CYC_PER_UNIT_DEF = int'(TIME_UNIT_NS / CLK_PERIOD_NS);
  typedef enum logic {SSD_RISE, SSD_FALL} ssd_phase_t;
endpackage : ssd_pkg

// [src/ssd_rate_limiter.sv]
`timescale 1ns/1ps
module ssd_rate_limiter #(
  parameter int CYC_PER_UNIT = ssd_pkg::CYC_PER_UNIT_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // target and ramp time in 0.01 s
  input wire logic signed [15:0] target,
  input wire logic [15:0] ramp_time,
  // limited value
  output logic signed [15:0] value_reg
);
  import ssd_pkg::*;

  logic [31:0] acc_reg;
  logic [31:0] acc_next;
  logic signed [15:0] value_next;
  wire [31:0] span = 32'(ramp_time) * 32'(CYC_PER_UNIT);
  wire [31:0] acc_sum = acc_reg + 32'(FULL_SCALE);
  wire at_target = (value_reg == target);
  wire step_now = (acc_sum >= span);

  // full scale per ramp time while span is at least full scale; a zero span jumps to the target, any other shorter span takes 16384 clocks at one count per clock
  always_comb begin
    value_next = value_reg;
    acc_next = acc_reg;
    if (span == 32'h0) begin
      value_next = target;
      acc_next = 32'h0;
    end else if (at_target) begin
      acc_next = 32'h0;
    end else if (step_now) begin
      acc_next = acc_sum - span;
      value_next = (target > value_reg) ? value_reg + 16'sh1 : value_reg - 16'sh1; // RULE_06 RULE_13
    end else begin
      acc_next = acc_sum;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      value_reg <= 16'sh0;
      acc_reg <= 32'h0;
    end else begin
      value_reg <= value_next;
      acc_reg <= acc_next;
    end
  end

  a_step_size: assert property (@(posedge clk) disable iff (!rst_b) // RULE_13
    (span != 32'h0 && $past(span) != 32'h0) |->
      (value_reg - $past(value_reg) <= 16'sh1 && $past(value_reg) - value_reg <= 16'sh1))
    else $error("limited value moved by more than one count");
endmodule : ssd_rate_limiter

// [src/ssd_top.sv]
`timescale 1ns/1ps
module ssd_top #(
  parameter int CYC_PER_UNIT = ssd_pkg::CYC_PER_UNIT_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [2:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rd_data,
  // set value path
  input wire logic signed [15:0] ramp_output_speed,
  input wire logic signed [15:0] second_analog_value,
  input wire logic signed [15:0] auxiliary_input_value,
  output logic signed [15:0] speed_setting,
  // status
  output logic sweep_active,
  output logic diam_active
);
  import ssd_pkg::*;

  localparam int NUM_W = 40;
  localparam int DEN_W = 25;
  // load at count 0, one shift per count 1..40 for all 40 numerator bits, result at 41
  localparam logic [5:0] DIV_STEPS = 6'd41;

  // register file
  logic [15:0] ext_function_mode_source_reg;
  logic [15:0] ext_function_digital_value_reg;
  logic [15:0] ext_function_ramp_time_reg;
  logic [15:0] sweep_rise_time_reg;
  logic [15:0] sweep_fall_time_reg;
  logic [15:0] diameter_ratio_reg;
  logic [15:0] rd_data_reg;

  wire wr_mode = wr_stb && (addr == REG_MODE);
  wire wr_digital = wr_stb && (addr == REG_DIGITAL);
  wire wr_ramp = wr_stb && (addr == REG_RAMP_TIME);
  wire wr_rise = wr_stb && (addr == REG_RISE_TIME);
  wire wr_fall = wr_stb && (addr == REG_FALL_TIME);
  wire wr_ratio = wr_stb && (addr == REG_RATIO);

  // out-of-range writes are clipped rather than refused, so software always sees a legal value
  wire signed [15:0] wr_signed = wr_data;
  wire [15:0] digital_clip = wr_signed < 16'sh0 ? 16'h0 :
    (wr_signed > FULL_SCALE ? 16'(FULL_SCALE) : wr_data); // RULE_05
  wire [15:0] time_clip = (wr_data > TIME_MAX) ? TIME_MAX : wr_data; // RULE_07
  wire [15:0] ratio_clip = (wr_data < RATIO_MIN) ? RATIO_MIN :
    ((wr_data > RATIO_MAX) ? RATIO_MAX : wr_data); // RULE_11

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_function_mode_source_reg <= RST_MODE;
      ext_function_digital_value_reg <= RST_DIGITAL;
      ext_function_ramp_time_reg <= RST_RAMP_TIME;
      sweep_rise_time_reg <= RST_RISE_TIME;
      sweep_fall_time_reg <= RST_FALL_TIME;
      diameter_ratio_reg <= RST_RATIO;
    end else begin
      if (wr_mode) ext_function_mode_source_reg <= wr_data;
      if (wr_digital) ext_function_digital_value_reg <= digital_clip;
      if (wr_ramp) ext_function_ramp_time_reg <= time_clip;
      if (wr_rise) sweep_rise_time_reg <= time_clip;
      if (wr_fall) sweep_fall_time_reg <= time_clip;
      if (wr_ratio) diameter_ratio_reg <= ratio_clip;
    end
  end

  // mode and source decode
  wire [3:0] mode_field = ext_function_mode_source_reg[MODE_MSB:MODE_LSB];
  wire [3:0] src_field = ext_function_mode_source_reg[SRC_MSB:SRC_LSB];
  wire sweep_on = (mode_field == MODE_SWEEP); // RULE_01
  wire diam_on = (mode_field == MODE_DIAM); // RULE_03

  // reserved and unlisted source codes give zero amplitude
  wire signed [15:0] src_raw =
    (src_field == SRC_AN2_A || src_field == SRC_AN2_B) ? second_analog_value :
    (src_field == SRC_DIGITAL) ? signed'(ext_function_digital_value_reg) :
    (src_field == SRC_AUX) ? auxiliary_input_value : 16'sh0; // RULE_04
  wire signed [15:0] src_clamped = (src_raw < 16'sh0) ? 16'sh0 :
    ((src_raw > FULL_SCALE) ? FULL_SCALE : src_raw); // RULE_09

  // one limiter serves both functions since only one can be active at a time
  logic signed [15:0] src_limited;
  ssd_rate_limiter #(
    .CYC_PER_UNIT(CYC_PER_UNIT)
  ) u_limiter (
    .clk(clk),
    .rst_b(rst_b),
    .target(src_clamped),
    .ramp_time(ext_function_ramp_time_reg),
    .value_reg(src_limited)
  );

  // sweep sawtooth
  ssd_phase_t phase_reg;
  logic [15:0] offset_reg;
  logic [31:0] sacc_reg;
  wire [15:0] amp = 16'(src_limited);
  wire [31:0] rise_span = 32'(sweep_rise_time_reg) * 32'(CYC_PER_UNIT);
  wire [31:0] fall_span = 32'(sweep_fall_time_reg) * 32'(CYC_PER_UNIT);
  wire [31:0] sacc_sum = sacc_reg + 32'(amp);
  wire rise_step = (sacc_sum >= rise_span);
  wire fall_step = (sacc_sum >= fall_span);

  // bresenham stepping: amplitude counts spread evenly over the span, no divider needed
  always_ff @(posedge clk) begin
    if (!rst_b || !sweep_on) begin
      phase_reg <= SSD_RISE;
      offset_reg <= 16'h0;
      sacc_reg <= 32'h0;
    end else begin
      unique case (phase_reg)
        SSD_RISE: begin
          if (offset_reg >= amp || rise_span == 32'h0) begin
            offset_reg <= amp; // RULE_08
            phase_reg <= SSD_FALL;
            sacc_reg <= 32'h0;
          end else if (rise_step) begin
            offset_reg <= offset_reg + 16'h1; // RULE_07 RULE_08
            sacc_reg <= sacc_sum - rise_span;
          end else begin
            sacc_reg <= sacc_sum;
          end
        end
        SSD_FALL: begin
          if (offset_reg > amp) begin
            offset_reg <= amp;
          end else if (offset_reg == 16'h0 || fall_span == 32'h0) begin
            offset_reg <= 16'h0; // RULE_08
            phase_reg <= SSD_RISE;
            sacc_reg <= 32'h0;
          end else if (fall_step) begin
            offset_reg <= offset_reg - 16'h1; // RULE_07 RULE_08
            sacc_reg <= sacc_sum - fall_span;
          end else begin
            sacc_reg <= sacc_sum;
          end
        end
      endcase
    end
  end

  // superimposed set value, saturated to the signed range
  wire signed [16:0] sweep_sum = 17'(ramp_output_speed) + 17'(signed'({1'b0, offset_reg})); // RULE_02
  wire signed [15:0] sweep_sat = (sweep_sum > 17'sh07fff) ? 16'sh7fff : 16'(sweep_sum);

  // diameter correction: out = in*R*FS / (R*FS + ds*(1000-R)), R in thousandths
  logic [NUM_W-1:0] num_reg;
  logic [DEN_W-1:0] rem_reg;
  logic [DEN_W-1:0] den_reg;
  logic [5:0] div_cnt_reg;
  logic neg_reg;
  logic ds_zero_reg;
  logic signed [15:0] in_lat_reg;
  logic signed [15:0] diam_speed_reg;

  wire [15:0] in_mag = ramp_output_speed[15] ? 16'(-ramp_output_speed) : ramp_output_speed;
  wire [9:0] ratio_q = diameter_ratio_reg[9:0];
  wire [NUM_W-1:0] num_load = (NUM_W'(in_mag) * NUM_W'(ratio_q)) << 14; // RULE_12
  wire [DEN_W-1:0] den_load = DEN_W'(ratio_q) * DEN_W'(FULL_SCALE) +
    DEN_W'(src_limited) * DEN_W'(RATIO_ONE - 11'(ratio_q)); // RULE_12
  wire [DEN_W:0] rem_shift = {rem_reg, num_reg[NUM_W-1]};
  wire rem_ge = rem_shift >= {1'b0, den_reg};
  wire div_done = (div_cnt_reg == DIV_STEPS);
  wire [15:0] quot = num_reg[15:0];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      num_reg <= '0;
      rem_reg <= '0;
      den_reg <= '0;
      div_cnt_reg <= 6'h0;
      neg_reg <= 1'b0;
      ds_zero_reg <= 1'b0;
      in_lat_reg <= 16'sh0;
      diam_speed_reg <= 16'sh0;
    end else if (div_cnt_reg == 6'h0) begin
      num_reg <= num_load;
      rem_reg <= '0;
      den_reg <= den_load;
      neg_reg <= ramp_output_speed[15];
      ds_zero_reg <= (src_limited == 16'sh0);
      in_lat_reg <= ramp_output_speed;
      div_cnt_reg <= 6'h1;
    end else if (div_done) begin
      diam_speed_reg <= neg_reg ? 16'(-quot) : 16'(quot); // RULE_10 RULE_12
      div_cnt_reg <= 6'h0;
    end else begin
      rem_reg <= rem_ge ? DEN_W'(rem_shift - {1'b0, den_reg}) : rem_shift[DEN_W-1:0];
      num_reg <= {num_reg[NUM_W-2:0], rem_ge};
      div_cnt_reg <= div_cnt_reg + 6'h1;
    end
  end

  // output selection
  logic signed [15:0] speed_setting_reg;
  logic sweep_active_reg;
  logic diam_active_reg;
  wire signed [15:0] speed_next = sweep_on ? sweep_sat :
    (diam_on ? diam_speed_reg : ramp_output_speed); // RULE_01 RULE_03

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      speed_setting_reg <= 16'sh0;
      sweep_active_reg <= 1'b0;
      diam_active_reg <= 1'b0;
    end else begin
      speed_setting_reg <= speed_next;
      sweep_active_reg <= sweep_on;
      diam_active_reg <= diam_on;
    end
  end

  // read data stands only in the cycle after the strobe
  wire [15:0] rd_mux =
    (addr == REG_MODE) ? ext_function_mode_source_reg :
    (addr == REG_DIGITAL) ? ext_function_digital_value_reg :
    (addr == REG_RAMP_TIME) ? ext_function_ramp_time_reg :
    (addr == REG_RISE_TIME) ? sweep_rise_time_reg :
    (addr == REG_FALL_TIME) ? sweep_fall_time_reg :
    (addr == REG_RATIO) ? diameter_ratio_reg :
    (addr == REG_STAT_SOURCE) ? 16'(src_limited) : offset_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data_reg <= 16'h0;
    end else begin
      rd_data_reg <= rd_stb ? rd_mux : 16'h0;
    end
  end

  assign rd_data = rd_data_reg;
  assign speed_setting = speed_setting_reg;
  assign sweep_active = sweep_active_reg;
  assign diam_active = diam_active_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_off_passthru: assert property ( // RULE_01
    (!sweep_on && !diam_on) |=> speed_setting == $past(ramp_output_speed))
    else $error("speed not passed through while off");

  a_sweep_flag: assert property ( // RULE_01
    sweep_active == $past(mode_field == MODE_SWEEP))
    else $error("sweep flag wrong for mode");

  a_diam_flag: assert property ( // RULE_03
    diam_active == $past(mode_field == MODE_DIAM))
    else $error("diameter flag wrong for mode");

  a_sweep_sum: assert property ( // RULE_02
    (sweep_on && sweep_sum <= 17'sh07fff) |=> speed_setting == $past(16'(sweep_sum)))
    else $error("sweep offset not added");

  a_source_aux: assert property ( // RULE_04
    (src_field == SRC_AUX) |-> src_raw == auxiliary_input_value)
    else $error("aux source not selected");

  a_digital_range: assert property ( // RULE_05
    signed'(ext_function_digital_value_reg) >= 16'sh0 &&
    signed'(ext_function_digital_value_reg) <= FULL_SCALE)
    else $error("digital value out of range");

  a_clamp_range: assert property ( // RULE_09
    src_clamped >= 16'sh0 && src_clamped <= FULL_SCALE)
    else $error("diameter signal not clamped");

  a_time_range: assert property ( // RULE_07
    sweep_rise_time_reg <= TIME_MAX && sweep_fall_time_reg <= TIME_MAX &&
    ext_function_ramp_time_reg <= TIME_MAX)
    else $error("time register out of range");

  a_ratio_range: assert property ( // RULE_11
    diameter_ratio_reg >= RATIO_MIN && diameter_ratio_reg <= RATIO_MAX)
    else $error("ratio out of range");

  sequence s_offset_moves;
    sweep_on && $past(sweep_on) && $past(phase_reg) == phase_reg;
  endsequence
  a_offset_linear: assert property ( // RULE_08
    s_offset_moves |-> (offset_reg - $past(offset_reg) <= 16'h1 ||
      $past(offset_reg) - offset_reg <= 16'h1 || offset_reg == amp))
    else $error("sweep offset jumped");

  sequence s_div_start;
    div_cnt_reg == 6'h0 && src_limited == 16'sh0;
  endsequence
  a_zero_diam: assert property ( // RULE_10
    s_div_start ##1 1'b1 |-> ##40 (div_done && ds_zero_reg) ##1 diam_speed_reg == in_lat_reg)
    else $error("zero diameter changed the speed");

  a_read_data: assert property (
    (rd_stb && addr == REG_RATIO && !wr_stb) |=> rd_data == diameter_ratio_reg)
    else $error("read data wrong");
endmodule : ssd_top

// [bench/ssd_far_end.sv]
`timescale 1ns/1ps
module ssd_far_end (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // levels commanded by the bench
  input wire logic signed [15:0] speed_cmd,
  input wire logic signed [15:0] an2_cmd,
  input wire logic signed [15:0] aux_cmd,
  // ramp generator and analog channel outputs
  output logic signed [15:0] ramp_output_speed,
  output logic signed [15:0] second_analog_value,
  output logic signed [15:0] auxiliary_input_value
);
  // registered, like the real ramp and input filter stages
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ramp_output_speed <= 16'sh0000;
      second_analog_value <= 16'sh0000;
      auxiliary_input_value <= 16'sh0000;
    end else begin
      ramp_output_speed <= speed_cmd;
      second_analog_value <= an2_cmd;
      auxiliary_input_value <= aux_cmd;
    end
  end
endmodule : ssd_far_end

// [bench/ssd_top_test.sv]
`timescale 1ns/1ps
module ssd_top_test;
  import ssd_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wr_data = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [15:0] rd_data, got;
  logic signed [15:0] speed_cmd = 16'sh0000, an2_cmd = 16'sh0000, aux_cmd = 16'sh0000;
  logic signed [15:0] ros, an2v, auxv, speed_setting, mx, mn, s0;
  logic sweep_active, diam_active;
  int miscompares = 0;
  int comparisons = 0;
  logic [15:0] rst_tab [6] = '{RST_MODE, RST_DIGITAL, RST_RAMP_TIME, RST_RISE_TIME,
    RST_FALL_TIME, RST_RATIO};
  logic [2:0] clip_a [6] = '{REG_RATIO, REG_RATIO, REG_RISE_TIME, REG_FALL_TIME,
    REG_DIGITAL, REG_DIGITAL};
  logic [15:0] clip_d [6] = '{16'h07d0, 16'h0005, 16'h0bb8, 16'h0bb9, 16'h5000, 16'hff00};
  logic [15:0] clip_e [6] = '{RATIO_MAX, RATIO_MIN, TIME_MAX, TIME_MAX, 16'h4000, 16'h0000};
  logic [15:0] off_tab [4] = '{16'h0000, 16'h0003, 16'h000f, 16'h0034};
  logic [3:0] src_tab [5] = '{SRC_AN2_A, SRC_AN2_B, 4'h2, SRC_DIGITAL, SRC_AUX};
  logic [15:0] src_exp [5] = '{16'h3000, 16'h3000, 16'h0000, 16'h1000, 16'h2000};
  logic signed [15:0] dia_in [4] = '{16'sd1000, 16'sd1000, 16'sd1000, -16'sd1000};
  logic [15:0] dia_ds [4] = '{16'h0000, 16'h4000, 16'h2000, 16'h4000};

  always #10 clk = ~clk;

  ssd_far_end ssd_far_end_inst (.clk(clk), .rst_b(rst_b), .speed_cmd(speed_cmd),
    .an2_cmd(an2_cmd), .aux_cmd(aux_cmd), .ramp_output_speed(ros),
    .second_analog_value(an2v), .auxiliary_input_value(auxv));

  // short time unit keeps the sweeps within a few thousand cycles; a full limiter swing at a nonzero ramp time still takes 16384 cycles
  ssd_top #(.CYC_PER_UNIT(5)) ssd_top_inst (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .ramp_output_speed(ros), .second_analog_value(an2v), .auxiliary_input_value(auxv),
    .speed_setting(speed_setting), .sweep_active(sweep_active), .diam_active(diam_active));

  function automatic logic [15:0] dia_exp(input longint v, input longint ds, input longint r);
    return 16'(v * r * 16384 / (r * 16384 + ds * (1000 - r)));
  endfunction : dia_exp

  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  // bounded poll; a poll that runs out fails its compare
  task automatic wait_reg(input logic [2:0] a, input logic [15:0] e, input int lim,
    input string nm);
    for (int i = 0; i < lim; i++) begin
      rd(a, got);
      if (got === e) break;
    end
    chk_word(nm, e, got);
    if (got !== e) stop_test();
  endtask : wait_reg

  task automatic wait_speed(input logic [15:0] e, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      #1;
      if (speed_setting === e) break;
    end
    chk_word("speed_setting", e, speed_setting);
    if (speed_setting !== e) stop_test();
  endtask : wait_speed

  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (7) @(posedge clk);
    #1 chk_word("speed in reset", 16'h0000, speed_setting);
    chk_bit("sweep in reset", 1'b0, sweep_active);
    chk_bit("diam in reset", 1'b0, diam_active);
    @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(3'(i), got);
      chk_word("reset value", rst_tab[i], got);
    end
    wr(REG_STAT_OFFSET, 16'h1234);
    rd(REG_STAT_OFFSET, got);
    chk_word("read-only offset", 16'h0000, got);
    wr(REG_RATIO, 16'h0123);
    rd(REG_RATIO, got);
    chk_word("ratio read", 16'h0123, got);
    @(posedge clk);
    #1 chk_word("read data idle", 16'h0000, rd_data);
    for (int i = 0; i < 6; i++) begin
      wr(clip_a[i], clip_d[i]);
      rd(clip_a[i], got);
      chk_word("clipped write", clip_e[i], got);
    end
    wr(REG_RATIO, 16'h01f4);
    wr(REG_RISE_TIME, 16'h0000);
    wr(REG_FALL_TIME, 16'h0000);
    wr(REG_DIGITAL, 16'h1000);
    speed_cmd <= 16'sd1000;
    an2_cmd <= 16'sh3000;
    aux_cmd <= 16'sh2000;
    for (int i = 0; i < 4; i++) begin
      wr(REG_MODE, off_tab[i]);
      wait_speed(16'd1000, 20);
      repeat (2) @(posedge clk);
      #1 chk_bit("sweep off", 1'b0, sweep_active);
      chk_bit("diam off", 1'b0, diam_active);
    end
    for (int i = 0; i < 5; i++) begin
      wr(REG_MODE, {8'h00, src_tab[i], MODE_DIAM});
      wait_reg(REG_STAT_SOURCE, src_exp[i], 20, "source value");
    end
    wr(REG_MODE, 16'h0002);
    an2_cmd <= -16'sd100;
    wait_reg(REG_STAT_SOURCE, 16'h0000, 20, "clamp low");
    an2_cmd <= 16'sh6000;
    wait_reg(REG_STAT_SOURCE, 16'h4000, 20, "clamp high");
    wr(REG_MODE, 16'h0032);
    for (int i = 0; i < 4; i++) begin
      speed_cmd <= dia_in[i];
      wr(REG_DIGITAL, dia_ds[i]);
      wait_speed(dia_exp(dia_in[i], dia_ds[i], 500), 300);
    end
    chk_bit("diam on", 1'b1, diam_active);
    chk_bit("sweep not on", 1'b0, sweep_active);
    speed_cmd <= 16'sd1000;
    wr(REG_DIGITAL, 16'h0000);
    wait_reg(REG_STAT_SOURCE, 16'h0000, 20, "limiter low");
    // limiter moves at most one count per cycle, so a full swing takes 16384 cycles here
    wr(REG_RAMP_TIME, 16'h0004);
    wr(REG_DIGITAL, 16'h4000);
    rd(REG_STAT_SOURCE, got);
    chk_bit("limiter not jumped", 1'b1, got !== 16'h4000);
    wait_reg(REG_STAT_SOURCE, 16'h4000, 10000, "limiter reach");
    wr(REG_RAMP_TIME, 16'h0000);
    wr(REG_DIGITAL, 16'h03e8);
    wr(REG_MODE, 16'h0031);
    wait_reg(REG_STAT_SOURCE, 16'h03e8, 20, "amplitude");
    #1 chk_bit("sweep on", 1'b1, sweep_active);
    chk_bit("diam not on", 1'b0, diam_active);
    s0 = speed_setting;
    @(posedge clk);
    #1 chk_word("sweep pair sum", 16'd3000, s0 + speed_setting);
    wr(REG_RISE_TIME, 16'h0002);
    wr(REG_FALL_TIME, 16'h0002);
    mx = 16'sh8000;
    mn = 16'sh7fff;
    repeat (5000) begin
      @(posedge clk);
      #1;
      if (speed_setting > mx) mx = speed_setting;
      if (speed_setting < mn) mn = speed_setting;
    end
    chk_word("sweep peak", 16'd2000, mx);
    chk_word("sweep floor", 16'd1000, mn);
    wr(REG_MODE, 16'h0000);
    wait_reg(REG_STAT_OFFSET, 16'h0000, 10, "offset cleared");
    wait_speed(16'd1000, 20);
    stop_test();
  end
endmodule : ssd_top_test
